// ---- core/ilw_pkg.sv ----
// Purpose: shared constants and types of the interrupt and wake block
// Assumes: 10 MHz core clock, one device end and one core end
// Notes: special function registers sit at their 8-bit addresses
package ilw_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int WAKE_TIME_MS = 2;
    localparam int WAKE_CYC = WAKE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int PD_GUARD_NS = 4000;
    localparam int PD_GUARD_CYC =
        (PD_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MC_CLKS = 12;
    localparam int RST_GRACE_MC = 2;
    localparam int RST_GRACE_CYC = MC_CLKS * RST_GRACE_MC;
    localparam int CNT_W = 16;
    localparam int RD_WAIT = 3;

    // ----------------------------------------------------------------
    // Special function registers
    // ----------------------------------------------------------------
    localparam logic [7:0] SFR_IE = 8'hA8;
    localparam logic [7:0] SFR_IPH = 8'hB7;
    localparam logic [7:0] SFR_IP = 8'hB8;
    localparam logic [7:0] IE_MASK = 8'hBF;
    localparam logic [7:0] PRIO_MASK = 8'h3F;
    localparam logic [7:0] SFR_RST = 8'h00;
    localparam int IE_GLOBAL = 7;
    localparam int NSRC = 6;
    localparam int SRC_EX0 = 0;
    localparam int SRC_T0 = 1;
    localparam int SRC_EX1 = 2;
    localparam int SRC_T1 = 3;
    localparam int SRC_SER = 4;
    localparam int SRC_T2 = 5;
    localparam logic [2:0] PIN_RST = 3'h3;
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;

    // ----------------------------------------------------------------
    // Core end register map
    // ----------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_SFR_ADDR = 8'h04;
    localparam logic [7:0] A_SFR_DATA = 8'h08;
    localparam logic [7:0] A_STATUS = 8'h0C;
    localparam int C_ACK = 0;
    localparam int C_RETI = 1;
    localparam int C_IDLE = 2;
    localparam int C_PD = 3;
    localparam int ST_REQ = 16;
    localparam int ST_HALT = 17;
    localparam int ST_RAMBLK = 18;
    localparam int ST_GUARD = 19;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    typedef enum logic [2:0] {
        PM_RUN, PM_IDLE, PM_RST_GRACE, PM_PD, PM_PD_RISE, PM_PD_TIME
    } ilw_pm_t;

endpackage

// ---- core/ilw_if.sv ----
// Purpose: link between interrupt controller and CPU core end
// Assumes: both ends on hclk
// Notes: all signals are driven from flip-flops of their owner
`timescale 1ns/1ns
interface ilw_if (
    input wire logic hclk,
    input wire logic hresetn
);
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic sfr_wr;
    logic irq_req;
    logic [15:0] irq_vector;
    logic irq_ack;
    logic irq_reti;
    logic idle_cmd;
    logic pd_cmd;
    logic cpu_halt;
    logic ram_block;
    logic core_reset;

    modport dev (
        input hclk, hresetn, sfr_addr, sfr_wdata, sfr_wr,
        input irq_ack, irq_reti, idle_cmd, pd_cmd,
        output sfr_rdata, irq_req, irq_vector, cpu_halt,
        output ram_block, core_reset
    );
    modport core (
        input hclk, hresetn, sfr_rdata, irq_req, irq_vector,
        input cpu_halt, ram_block, core_reset,
        output sfr_addr, sfr_wdata, sfr_wr,
        output irq_ack, irq_reti, idle_cmd, pd_cmd
    );
endinterface

// ---- core/ilw_dev.sv ----
// Purpose: interrupt controller with idle and power-down handling
// Assumes: timer and serial flags come from logic on hclk
// Notes: pins pass a three-stage filter before use
`timescale 1ns/1ns
module ilw_dev #(
    parameter int WAKE_CYCLES = ilw_pkg::WAKE_CYC
) (
    // Core side
    ilw_if.dev bus,
    // External pins
    input wire logic ext_irq0_pin,
    input wire logic ext_irq1_pin,
    input wire logic rst_pin,
    // Peripheral flags
    input wire logic timer0_overflow_flag,
    input wire logic timer1_overflow_flag,
    input wire logic timer2_overflow_flag,
    input wire logic timer2_external_flag,
    input wire logic uart_rx_done_flag,
    input wire logic uart_tx_done_flag,
    input wire logic spi_done_flag,
    input wire logic spi_irq_enable,
    // Configuration and core strobes
    input wire logic wake_edge_select,
    input wire logic ext_prog_mem,
    input wire logic cpu_ale_in,
    input wire logic cpu_fetch_in,
    // Outputs
    output logic ale,
    output logic code_fetch_strobe,
    output logic port0_float,
    output logic osc_stop,
    output logic [5:0] src_ack
);
    import ilw_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Returns {found, level, index}; last hit is highest level, first
    // source in fixed order within it
    function automatic logic [5:0] ilw_pick(
        input logic [5:0] pend,
        input logic [5:0] hi,
        input logic [5:0] lo,
        input logic [3:0] busy
    );
        logic [5:0] r;
        r = '0;
        for (int l = 0; l < 4; l++)
        begin
            for (int i = NSRC - 1; i >= 0; i--)
            begin
                if (pend[i] && {hi[i], lo[i]} == 2'(l)
                    && (busy >> l) == 4'h0)
                begin
                    r = {1'b1, 2'(l), 3'(i)};
                end
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] ilw_vec(input logic [2:0] idx);
        return VEC_BASE + VEC_STEP * {13'h0, idx};
    endfunction

    // ----------------------------------------------------------------
    // Pin filter
    // ----------------------------------------------------------------
    logic [2:0] s1_ff, s2_ff, s3_ff, pin_ff;
    logic [2:0] agree;
    assign agree = ~(s2_ff ^ s3_ff);

    always_ff @(posedge bus.hclk or negedge bus.hresetn)
    begin
        if (!bus.hresetn)
        begin
            s1_ff <= PIN_RST;
            s2_ff <= PIN_RST;
            s3_ff <= PIN_RST;
            pin_ff <= PIN_RST;
        end
        else
        begin
            s1_ff <= {rst_pin, ext_irq1_pin, ext_irq0_pin};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            pin_ff <= (s3_ff & agree) | (pin_ff & ~agree);
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] ie_ff, iph_ff, ip_ff, sfr_rdata_ff;
    logic core_reset_ff;

    always_ff @(posedge bus.hclk or negedge bus.hresetn)
    begin
        if (!bus.hresetn)
        begin
            ie_ff <= SFR_RST;
            iph_ff <= SFR_RST;
            ip_ff <= SFR_RST;
        end
        else if (core_reset_ff)
        begin
            ie_ff <= SFR_RST;
            iph_ff <= SFR_RST;
            ip_ff <= SFR_RST;
        end
        else if (bus.sfr_wr)
        begin
            case (bus.sfr_addr)
                SFR_IE: ie_ff <= bus.sfr_wdata & IE_MASK;
                SFR_IPH: iph_ff <= bus.sfr_wdata & PRIO_MASK;
                SFR_IP: ip_ff <= bus.sfr_wdata & PRIO_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge bus.hclk or negedge bus.hresetn)
    begin
        if (!bus.hresetn)
            sfr_rdata_ff <= SFR_RST;
        else
        begin
            case (bus.sfr_addr)
                SFR_IE: sfr_rdata_ff <= ie_ff;
                SFR_IPH: sfr_rdata_ff <= iph_ff;
                SFR_IP: sfr_rdata_ff <= ip_ff;
                default: sfr_rdata_ff <= SFR_RST;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Requests
    // ----------------------------------------------------------------
    logic t0_ff, t1_ff;
    logic [5:0] req, pend, sel;

    always_ff @(posedge bus.hclk or negedge bus.hresetn)
    begin
        if (!bus.hresetn)
        begin
            t0_ff <= 1'b0;
            t1_ff <= 1'b0;
        end
        else
        begin
            t0_ff <= timer0_overflow_flag;
            t1_ff <= timer1_overflow_flag;
        end
    end

    always_comb
    begin
        req = '0;
        req[SRC_EX0] = ~pin_ff[0];
        req[SRC_T0] = t0_ff;
        req[SRC_EX1] = ~pin_ff[1];
        req[SRC_T1] = t1_ff;
        req[SRC_SER] = uart_rx_done_flag | uart_tx_done_flag
            | (spi_done_flag & spi_irq_enable);
        req[SRC_T2] = timer2_overflow_flag
            | timer2_external_flag;
    end

    assign pend = req & ie_ff[5:0] & {NSRC{ie_ff[IE_GLOBAL]}};

    // ----------------------------------------------------------------
    // Arbitration and service levels
    // ----------------------------------------------------------------
    logic [3:0] insvc_ff, nxt_insvc;
    logic irq_req_ff;
    logic [15:0] vec_ff;
    logic [1:0] lvl_ff;
    logic [2:0] idx_ff;
    ilw_pm_t pm_ff, nxt_pm;
    logic took;

    assign sel = ilw_pick(pend, iph_ff[5:0], ip_ff[5:0], insvc_ff);
    assign took = bus.irq_ack && irq_req_ff;

    always_comb
    begin
        nxt_insvc = insvc_ff;
        if (bus.irq_reti)
        begin
            for (int l = 0; l < 4; l++)
            begin
                if ((insvc_ff >> l) == 4'h1)
                    nxt_insvc[l] = 1'b0;
            end
        end
        if (took)
            nxt_insvc[lvl_ff] = 1'b1;
    end

    always_ff @(posedge bus.hclk or negedge bus.hresetn)
    begin
        if (!bus.hresetn)
        begin
            insvc_ff <= '0;
            irq_req_ff <= 1'b0;
            vec_ff <= VEC_RESET;
            lvl_ff <= '0;
            idx_ff <= '0;
            src_ack <= '0;
        end
        else if (core_reset_ff)
        begin
            insvc_ff <= '0;
            irq_req_ff <= 1'b0;
            vec_ff <= VEC_RESET;
            src_ack <= '0;
        end
        else
        begin
            insvc_ff <= nxt_insvc;
            irq_req_ff <= sel[5] && !took && pm_ff == PM_RUN;
            if (sel[5])
            begin
                vec_ff <= ilw_vec(sel[2:0]);
                lvl_ff <= sel[4:3];
                idx_ff <= sel[2:0];
            end
            src_ack <= took ? 6'(1 << idx_ff) : '0;
        end
    end

    // ----------------------------------------------------------------
    // Power modes
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic nxt_core_reset, wake_low, rst_in;

    assign rst_in = pin_ff[2];
    assign wake_low = ie_ff[IE_GLOBAL]
        && ((ie_ff[SRC_EX0] && !pin_ff[0])
        || (ie_ff[SRC_EX1] && !pin_ff[1]));

    always_comb
    begin
        nxt_pm = pm_ff;
        nxt_cnt = cnt_ff;
        nxt_core_reset = 1'b0;
        case (pm_ff)
            PM_RUN:
            begin
                if (rst_in)
                    nxt_core_reset = 1'b1;
                else if (bus.idle_cmd)
                    nxt_pm = PM_IDLE;
                else if (bus.pd_cmd)
                    nxt_pm = PM_PD;
            end
            PM_IDLE:
            begin
                if (rst_in)
                begin
                    nxt_pm = PM_RST_GRACE;
                    nxt_cnt = CNT_W'(RST_GRACE_CYC - 1);
                end
                else if (|pend)
                    nxt_pm = PM_RUN;
            end
            PM_RST_GRACE:
            begin
                if (cnt_ff == '0)
                begin
                    nxt_pm = PM_RUN;
                    nxt_core_reset = 1'b1;
                end
                else
                    nxt_cnt = cnt_ff - 1'b1;
            end
            PM_PD:
            begin
                if (rst_in)
                begin
                    nxt_pm = PM_RUN;
                    nxt_core_reset = 1'b1;
                end
                else if (wake_low && wake_edge_select)
                    nxt_pm = PM_PD_RISE;
                else if (wake_low)
                begin
                    nxt_pm = PM_PD_TIME;
                    nxt_cnt = CNT_W'(WAKE_CYCLES - 1);
                end
            end
            PM_PD_RISE:
            begin
                if (!wake_low)
                    nxt_pm = PM_RUN;
            end
            PM_PD_TIME:
            begin
                if (cnt_ff == '0)
                    nxt_pm = PM_RUN;
                else
                    nxt_cnt = cnt_ff - 1'b1;
            end
            default: nxt_pm = PM_RUN;
        endcase
    end

    logic halt_ff, ram_block_ff;

    always_ff @(posedge bus.hclk or negedge bus.hresetn)
    begin
        if (!bus.hresetn)
        begin
            pm_ff <= PM_RUN;
            cnt_ff <= '0;
            core_reset_ff <= 1'b0;
            halt_ff <= 1'b0;
            ram_block_ff <= 1'b0;
            osc_stop <= 1'b0;
        end
        else
        begin
            pm_ff <= nxt_pm;
            cnt_ff <= nxt_cnt;
            core_reset_ff <= nxt_core_reset;
            halt_ff <= nxt_pm != PM_RUN;
            ram_block_ff <= nxt_pm == PM_RST_GRACE;
            osc_stop <= nxt_pm == PM_PD;
        end
    end

    // ----------------------------------------------------------------
    // Pin states
    // ----------------------------------------------------------------
    always_ff @(posedge bus.hclk or negedge bus.hresetn)
    begin
        if (!bus.hresetn)
        begin
            ale <= 1'b1;
            code_fetch_strobe <= 1'b1;
            port0_float <= 1'b0;
        end
        else
        begin
            case (nxt_pm)
                PM_RUN:
                begin
                    ale <= cpu_ale_in;
                    code_fetch_strobe <= cpu_fetch_in;
                end
                PM_IDLE, PM_RST_GRACE:
                begin
                    ale <= 1'b1;
                    code_fetch_strobe <= 1'b1;
                end
                default:
                begin
                    ale <= 1'b0;
                    code_fetch_strobe <= 1'b0;
                end
            endcase
            port0_float <= ext_prog_mem && nxt_pm != PM_RUN;
        end
    end

    assign bus.sfr_rdata = sfr_rdata_ff;
    assign bus.irq_req = irq_req_ff;
    assign bus.irq_vector = vec_ff;
    assign bus.cpu_halt = halt_ff;
    assign bus.ram_block = ram_block_ff;
    assign bus.core_reset = core_reset_ff;

endmodule

// ---- core/ilw_core.sv ----
// Purpose: CPU core end, driven by software over AHB-Lite
// Assumes: single word transfers, one slave on the bus
// Notes: reads take RD_WAIT wait cycles, writes none
`timescale 1ns/1ns
module ilw_core (
    // Link to controller
    ilw_if.core bus,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp
);
    import ilw_pkg::*;

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic [7:0] aph_ff, sfr_addr_ff, sfr_wdata_ff;
    logic wr_ff, sfr_wr_ff;
    logic [1:0] rd_cnt_ff;
    logic ack_ff, reti_ff, idle_ff, pd_ff, halt_q_ff;
    logic [CNT_W-1:0] guard_ff;
    logic [31:0] status;
    logic take;

    assign take = hsel && hready && htrans == HTRANS_NONSEQ;
    assign hresp = HRESP_OKAY;

    always_comb
    begin
        status = '0;
        status[15:0] = bus.irq_vector;
        status[ST_REQ] = bus.irq_req;
        status[ST_HALT] = bus.cpu_halt;
        status[ST_RAMBLK] = bus.ram_block;
        status[ST_GUARD] = guard_ff != '0;
    end

    always_ff @(posedge bus.hclk or negedge bus.hresetn)
    begin
        if (!bus.hresetn)
        begin
            aph_ff <= '0;
            wr_ff <= 1'b0;
            rd_cnt_ff <= '0;
            hreadyout <= 1'b1;
            hrdata <= '0;
        end
        else
        begin
            wr_ff <= take && hwrite;
            if (take)
                aph_ff <= haddr[7:0];
            if (take && !hwrite)
            begin
                rd_cnt_ff <= 2'(RD_WAIT);
                hreadyout <= 1'b0;
            end
            else if (rd_cnt_ff == 2'h1)
            begin
                rd_cnt_ff <= '0;
                hreadyout <= 1'b1;
                case (aph_ff)
                    A_SFR_ADDR: hrdata <= {24'h0, sfr_addr_ff};
                    A_SFR_DATA: hrdata <= {24'h0, bus.sfr_rdata};
                    A_STATUS: hrdata <= status;
                    default: hrdata <= '0;
                endcase
            end
            else if (rd_cnt_ff != '0)
                rd_cnt_ff <= rd_cnt_ff - 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Commands to the controller
    // ----------------------------------------------------------------
    always_ff @(posedge bus.hclk or negedge bus.hresetn)
    begin
        if (!bus.hresetn)
        begin
            sfr_addr_ff <= '0;
            sfr_wdata_ff <= '0;
            sfr_wr_ff <= 1'b0;
            ack_ff <= 1'b0;
            reti_ff <= 1'b0;
            idle_ff <= 1'b0;
            pd_ff <= 1'b0;
        end
        else
        begin
            sfr_wr_ff <= 1'b0;
            ack_ff <= 1'b0;
            reti_ff <= 1'b0;
            idle_ff <= 1'b0;
            pd_ff <= 1'b0;
            if (wr_ff && aph_ff == A_SFR_ADDR)
                sfr_addr_ff <= hwdata[7:0];
            if (wr_ff && aph_ff == A_SFR_DATA)
            begin
                sfr_wdata_ff <= hwdata[7:0];
                sfr_wr_ff <= 1'b1;
            end
            if (wr_ff && aph_ff == A_CTRL)
            begin
                ack_ff <= hwdata[C_ACK] && bus.irq_req;
                reti_ff <= hwdata[C_RETI];
                idle_ff <= hwdata[C_IDLE] && !bus.cpu_halt;
                pd_ff <= hwdata[C_PD] && !bus.cpu_halt
                    && guard_ff == '0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Power-down guard after start or wake
    // ----------------------------------------------------------------
    always_ff @(posedge bus.hclk or negedge bus.hresetn)
    begin
        if (!bus.hresetn)
        begin
            guard_ff <= CNT_W'(PD_GUARD_CYC);
            halt_q_ff <= 1'b0;
        end
        else
        begin
            halt_q_ff <= bus.cpu_halt;
            if (bus.core_reset || (halt_q_ff && !bus.cpu_halt))
                guard_ff <= CNT_W'(PD_GUARD_CYC);
            else if (guard_ff != '0)
                guard_ff <= guard_ff - 1'b1;
        end
    end

    assign bus.sfr_addr = sfr_addr_ff;
    assign bus.sfr_wdata = sfr_wdata_ff;
    assign bus.sfr_wr = sfr_wr_ff;
    assign bus.irq_ack = ack_ff;
    assign bus.irq_reti = reti_ff;
    assign bus.idle_cmd = idle_ff;
    assign bus.pd_cmd = pd_ff;

endmodule

// ---- dv/ilw_checker.sv ----
// Purpose: assertions on the controller to core link
// Assumes: one clock domain, reset active low
// Notes: watches link signals only
`timescale 1ns/1ns
module ilw_checker
    import ilw_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Link
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_wr,
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic irq_ack,
    input wire logic idle_cmd,
    input wire logic cpu_halt,
    input wire logic ram_block
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_rst_vec;
        $rose(hresetn) |-> irq_vector == VEC_RESET && !irq_req;
    endproperty
    a_rst_vec: assert property (p_rst_vec)
        else $error("vector not cleared");
    property p_vec;
        irq_req |-> irq_vector inside {16'h0003, 16'h000B, 16'h0013,
            16'h001B, 16'h0023, 16'h002B};
    endproperty
    a_vec: assert property (p_vec)
        else $error("bad vector");
    property p_ack;
        irq_ack && irq_req |=> !irq_req;
    endproperty
    a_ack: assert property (p_ack)
        else $error("request kept after ack");
    property p_idle;
        idle_cmd |-> ##[1:2] cpu_halt;
    endproperty
    a_idle: assert property (p_idle)
        else $error("no halt on idle");
    property p_noreq;
        cpu_halt && $past(cpu_halt) |-> !irq_req;
    endproperty
    a_noreq: assert property (p_noreq)
        else $error("request while halted");
    property p_ram;
        $rose(ram_block) |=> ram_block[*8];
    endproperty
    a_ram: assert property (p_ram)
        else $error("ram block too short");
    property p_ie;
        sfr_wr && sfr_addr == SFR_IE ##2 sfr_addr == SFR_IE
            |-> sfr_rdata == ($past(sfr_wdata, 2) & IE_MASK);
    endproperty
    a_ie: assert property (p_ie)
        else $error("enable readback");
    property p_prio;
        sfr_wr && (sfr_addr == SFR_IP || sfr_addr == SFR_IPH)
            ##2 sfr_addr == $past(sfr_addr, 2)
            |-> sfr_rdata == ($past(sfr_wdata, 2) & PRIO_MASK);
    endproperty
    a_prio: assert property (p_prio)
        else $error("priority readback");
endmodule

// ---- dv/tb.sv ----
// Purpose: self-checking bench of controller and core end
// Assumes: 10 MHz hclk, wake count shortened to 20
// Notes: software side speaks AHB-Lite single words
`timescale 1ns/1ns
module tb;
    import ilw_pkg::*;
    logic hclk, hreadyout, hresp, ale, code_fetch_strobe;
    logic port0_float, osc_stop;
    logic [5:0] src_ack, ack_seen = 6'h0;
    logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rst_pin = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [8:0] s_q = 9'h0;
    logic spi_irq_enable = 1'b1, wake_edge_select = 1'b0;
    logic ext_prog_mem = 1'b0, cpu_ale_in = 1'b0, cpu_fetch_in = 1'b0;
    int n_errors = 0;
    int n_tests = 0;
    int ix[9] = '{0, 1, 2, 3, 4, 5, 4, 4, 5};
    ilw_if ilw_if_inst (.hclk, .hresetn);
    ilw_dev #(.WAKE_CYCLES(20)) ilw_dev_inst (.bus(ilw_if_inst),
        .ext_irq0_pin(!s_q[0]), .timer0_overflow_flag(s_q[1]),
        .ext_irq1_pin(!s_q[2]), .timer1_overflow_flag(s_q[3]),
        .uart_rx_done_flag(s_q[4]), .timer2_overflow_flag(s_q[5]),
        .uart_tx_done_flag(s_q[6]), .spi_done_flag(s_q[7]),
        .timer2_external_flag(s_q[8]), .rst_pin, .spi_irq_enable,
        .wake_edge_select, .ext_prog_mem, .cpu_ale_in, .cpu_fetch_in,
        .ale, .code_fetch_strobe, .port0_float, .osc_stop, .src_ack);
    ilw_core ilw_core_inst (.bus(ilw_if_inst), .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
        .hrdata, .hresp);
    ilw_checker ilw_checker_inst (.hclk, .hresetn,
        .sfr_addr(ilw_if_inst.sfr_addr), .sfr_wr(ilw_if_inst.sfr_wr),
        .sfr_wdata(ilw_if_inst.sfr_wdata),
        .sfr_rdata(ilw_if_inst.sfr_rdata), .irq_req(ilw_if_inst.irq_req),
        .irq_vector(ilw_if_inst.irq_vector),
        .irq_ack(ilw_if_inst.irq_ack), .idle_cmd(ilw_if_inst.idle_cmd),
        .cpu_halt(ilw_if_inst.cpu_halt),
        .ram_block(ilw_if_inst.ram_block));

    // Collects the one-cycle source acknowledge pulses
    always @(posedge hclk)
        if (hresetn)
            ack_seen <= ack_seen | src_ack;

    task stop_test;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Waits for hready sampled high at a rising edge
    task wt;
        int i;
        for (i = 0; i < 60; i++)
        begin
            @(posedge hclk);
            if (hreadyout === 1'b1)
                break;
        end
        if (i == 60)
        begin
            chk(32'h0, 32'h1);
            stop_test;
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h0, a};
        wt;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt;
        r = hrdata;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(r & m, e);
    endtask
    task sw(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, A_SFR_ADDR, {24'h0, a});
        xfer(1'b1, A_SFR_DATA, {24'h0, d});
    endtask
    task sr(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b1, A_SFR_ADDR, {24'h0, a});
        rd(A_SFR_DATA, 32'hFF, {24'h0, e});
    endtask
    task src(input logic [8:0] s);
        @(posedge hclk);
        s_q <= s;
        repeat (5) @(posedge hclk);
    endtask
    task pins(input logic [3:0] e);
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        chk({ale, code_fetch_strobe, osc_stop, port0_float}, {28'h0, e});
    endtask

    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rd(A_STATUS, 32'h7FFFF, 32'h0);
        sw(SFR_IE, 8'hBF);
        sr(SFR_IE, 8'hBF);
        sw(SFR_IP, 8'h3F);
        sr(SFR_IP, 8'h3F);
        sw(SFR_IPH, 8'h3F);
        sr(SFR_IPH, 8'h3F);
        sw(SFR_IP, 8'h00);
        sw(SFR_IPH, 8'h00);
        for (int k = 0; k < 9; k++)
        begin
            src(9'h1 << k);
            sw(SFR_IE, 8'h80 | (8'h1 << ix[k]));
            rd(A_STATUS, 32'h1FFFF, 32'h10003 + 8 * ix[k]);
            sw(SFR_IE, 8'h1 << ix[k]);
            rd(A_STATUS, 32'h10000, 32'h0);
        end
        spi_irq_enable <= 1'b0;
        src(9'h080);
        sw(SFR_IE, 8'h90);
        rd(A_STATUS, 32'h10000, 32'h0);
        src(9'h003);
        sw(SFR_IE, 8'h83);
        sw(SFR_IP, 8'h02);
        rd(A_STATUS, 32'h1FFFF, 32'h1000B);
        xfer(1'b1, A_CTRL, 32'h1);
        rd(A_STATUS, 32'h10000, 32'h0);
        chk({26'h0, ack_seen}, 32'h2);
        xfer(1'b1, A_CTRL, 32'h2);
        rd(A_STATUS, 32'h1FFFF, 32'h1000B);
        sw(SFR_IP, 8'h03);
        rd(A_STATUS, 32'h1FFFF, 32'h10003);
        sw(SFR_IPH, 8'h02);
        rd(A_STATUS, 32'h1FFFF, 32'h1000B);
        src(9'h000);
        sw(SFR_IP, 8'h00);
        sw(SFR_IPH, 8'h00);
        sw(SFR_IE, 8'h81);
        xfer(1'b1, A_CTRL, 32'h4);
        rd(A_STATUS, 32'h20000, 32'h20000);
        pins(4'hC);
        src(9'h001);
        rd(A_STATUS, 32'h20000, 32'h0);
        src(9'h000);
        xfer(1'b1, A_CTRL, 32'h4);
        rst_pin <= 1'b1;
        repeat (4) @(posedge hclk);
        rd(A_STATUS, 32'h40000, 32'h40000);
        repeat (30) @(posedge hclk);
        rst_pin <= 1'b0;
        sr(SFR_IE, 8'h00);
        sw(SFR_IE, 8'h81);
        wake_edge_select <= 1'b1;
        ext_prog_mem <= 1'b1;
        cpu_ale_in <= 1'b1;
        cpu_fetch_in <= 1'b1;
        repeat (45) @(posedge hclk);
        xfer(1'b1, A_CTRL, 32'h8);
        pins(4'h3);
        src(9'h001);
        rd(A_STATUS, 32'h20000, 32'h20000);
        src(9'h000);
        repeat (5) @(posedge hclk);
        pins(4'hC);
        rd(A_STATUS, 32'hA0000, 32'h80000);
        xfer(1'b1, A_CTRL, 32'h8);
        rd(A_STATUS, 32'h20000, 32'h0);
        repeat (30) @(posedge hclk);
        wake_edge_select <= 1'b0;
        xfer(1'b1, A_CTRL, 32'h8);
        src(9'h001);
        repeat (12) @(posedge hclk);
        rd(A_STATUS, 32'h20000, 32'h20000);
        rd(A_STATUS, 32'h20000, 32'h0);
        stop_test;
    end
endmodule
